// ### src/emss_pkg.sv
// Constants shared by the external memory write strobe and select pin logic.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
package emss_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEL_N = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned WR_SETUP_NS = 8;
  localparam int unsigned WR_PULSE_NS = 24;
  // Least times round up to whole cycles, never below one
  localparam int unsigned WR_SETUP_CYC_I = (WR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_PULSE_CYC_I = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] WR_SETUP_CYC = (WR_SETUP_CYC_I < 1) ? 4'h1 : 4'(WR_SETUP_CYC_I);
  localparam logic [3:0] WR_PULSE_CYC = (WR_PULSE_CYC_I < 1) ? 4'h1 : 4'(WR_PULSE_CYC_I);

  // ****************************************************************
  // Pin field positions and reset values
  // ****************************************************************
  localparam int unsigned PUR_PROG_SEL_BIT = 8;
  localparam int unsigned PUR_DATA_SEL_BIT = 9;
  localparam logic SPACE_PROG = 1'h0;
  localparam logic SPACE_DATA = 1'h1;
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic PULLUP_RESET = 1'h1;
  localparam logic OE_RESET = 1'h0;

  // Write cycle sequencer
  typedef enum logic [1:0] {
    EMSS_IDLE,
    EMSS_SETUP,
    EMSS_STROBE,
    EMSS_HOLD
  } emss_state_t;

endpackage : emss_pkg

// ### src/emss_sel_pin.sv
// One select pin: either a chip select from the memory interface or a port D line.
// Assumes pin_i comes from the pad, outside the clock domain.
`timescale 1ns/1ps
module emss_sel_pin (
  input wire logic clock,
  input wire logic rst,
  input wire logic emi_sel_n,
  input wire logic emi_oe,
  input wire logic gpio_mode,
  input wire logic gpio_dir,
  input wire logic gpio_out,
  input wire logic pu_en,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic pin_pu,
  output logic gpio_in
);

  // ****************************************************************
  // Pin state
  // ****************************************************************
  logic pin_o_nxt;
  logic pin_oe_nxt;
  logic pin_pu_nxt;
  logic sync1_r;
  logic sync2_r;

  // Choose select function or general-purpose line
  always_comb begin
    if (gpio_mode) begin
      pin_o_nxt = gpio_out;
      pin_oe_nxt = gpio_dir;
    end else begin
      pin_o_nxt = emi_sel_n;
      pin_oe_nxt = emi_oe;
    end
    pin_pu_nxt = pu_en;
  end

  // Register pin drive; reset leaves pin undriven and pulled up
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_o <= emss_pkg::STROBE_IDLE;
      pin_oe <= emss_pkg::OE_RESET;
      pin_pu <= emss_pkg::PULLUP_RESET;
      sync1_r <= 1'h1;
      sync2_r <= 1'h1;
      gpio_in <= 1'h1;
    end else begin
      pin_o <= pin_o_nxt;
      pin_oe <= pin_oe_nxt;
      pin_pu <= pin_pu_nxt;
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      gpio_in <= sync2_r;
    end
  end

endmodule : emss_sel_pin

// ### src/emss_top.sv
// Write strobe, data direction and program/data select pins of the external bus.
// Assumes configuration bits come from registers on the same clock.
`timescale 1ns/1ps
module emss_top (
  input wire logic clock,
  input wire logic rst,
  // Write request from the core
  input wire logic wr_req,
  input wire logic [23:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_space,
  output logic wr_busy,
  output logic wr_done,
  // Read access in progress elsewhere on the bus
  input wire logic rd_active,
  input wire logic rd_space,
  // Configuration bits
  input wire logic bus_idle_drive_bit,
  input wire logic ctrl_pullup_disable,
  input wire logic [15:0] portd_pullup_enable_reg,
  input wire logic [1:0] portd_gpio_mode,
  input wire logic [1:0] portd_gpio_dir,
  input wire logic [1:0] portd_gpio_out,
  output logic [1:0] portd_gpio_in,
  // Pins
  output logic write_strobe_n_o,
  output logic write_strobe_oe,
  output logic write_strobe_pu,
  output logic [23:0] addr_o,
  output logic [15:0] data_o,
  output logic data_oe,
  input wire logic [1:0] sel_i,
  output logic [1:0] sel_o,
  output logic [1:0] sel_oe,
  output logic [1:0] sel_pu
);

  // ****************************************************************
  // Write cycle sequencer
  // ****************************************************************
  emss_pkg::emss_state_t state_r;
  emss_pkg::emss_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [23:0] addr_nxt;
  logic [15:0] data_nxt;
  logic space_r;
  logic space_nxt;
  logic wr_busy_nxt;
  logic wr_done_nxt;

  // Setup, strobe low for the pulse count, then one hold cycle
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_o;
    data_nxt = data_o;
    space_nxt = space_r;
    wr_done_nxt = 1'h0;
    unique case (state_r)
      emss_pkg::EMSS_IDLE: begin
        if (wr_req && !rd_active) begin
          state_nxt = emss_pkg::EMSS_SETUP;
          cnt_nxt = emss_pkg::WR_SETUP_CYC;
          addr_nxt = wr_addr;
          data_nxt = wr_data;
          space_nxt = wr_space;
        end
      end
      emss_pkg::EMSS_SETUP: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = emss_pkg::EMSS_STROBE;
          cnt_nxt = emss_pkg::WR_PULSE_CYC;
        end
      end
      emss_pkg::EMSS_STROBE: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = emss_pkg::EMSS_HOLD;
        end
      end
      emss_pkg::EMSS_HOLD: begin
        state_nxt = emss_pkg::EMSS_IDLE;
        wr_done_nxt = 1'h1;
      end
    endcase
    wr_busy_nxt = (state_nxt != emss_pkg::EMSS_IDLE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= emss_pkg::EMSS_IDLE;
      cnt_r <= 4'h0;
      addr_o <= 24'h000000;
      data_o <= 16'h0000;
      space_r <= emss_pkg::SPACE_PROG;
      wr_busy <= 1'h0;
      wr_done <= 1'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      addr_o <= addr_nxt;
      data_o <= data_nxt;
      space_r <= space_nxt;
      wr_busy <= wr_busy_nxt;
      wr_done <= wr_done_nxt;
    end
  end

  // ****************************************************************
  // Strobe and data pin drive
  // ****************************************************************
  logic bus_active_nxt;
  logic space_act_nxt;
  logic strobe_n_nxt;
  logic strobe_oe_nxt;
  logic data_oe_nxt;
  logic [1:0] emi_sel_n_nxt;
  logic [1:0] emi_oe_nxt;
  logic [1:0] sel_pu_en;

  // Outputs computed from the next state so pins line up with the sequencer
  always_comb begin
    bus_active_nxt = (state_nxt != emss_pkg::EMSS_IDLE) || rd_active;
    space_act_nxt = (state_nxt != emss_pkg::EMSS_IDLE) ? space_nxt : rd_space;
    strobe_n_nxt = (state_nxt == emss_pkg::EMSS_STROBE) ? 1'h0 : emss_pkg::STROBE_IDLE;
    // Data held through the hold cycle so it is valid at the rising edge
    data_oe_nxt = (state_nxt == emss_pkg::EMSS_STROBE) ||
                  (state_nxt == emss_pkg::EMSS_HOLD);
    strobe_oe_nxt = bus_active_nxt || bus_idle_drive_bit;
    // Selects low only for the space being accessed, with the address stable
    emi_sel_n_nxt[0] = !(bus_active_nxt && space_act_nxt == emss_pkg::SPACE_PROG);
    emi_sel_n_nxt[1] = !(bus_active_nxt && space_act_nxt == emss_pkg::SPACE_DATA);
    emi_oe_nxt[0] = bus_active_nxt || bus_idle_drive_bit;
    emi_oe_nxt[1] = bus_active_nxt || bus_idle_drive_bit;
    sel_pu_en[0] = portd_pullup_enable_reg[emss_pkg::PUR_PROG_SEL_BIT];
    sel_pu_en[1] = portd_pullup_enable_reg[emss_pkg::PUR_DATA_SEL_BIT];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      write_strobe_n_o <= emss_pkg::STROBE_IDLE;
      write_strobe_oe <= emss_pkg::OE_RESET;
      write_strobe_pu <= emss_pkg::PULLUP_RESET;
      data_oe <= emss_pkg::OE_RESET;
    end else begin
      write_strobe_n_o <= strobe_n_nxt;
      write_strobe_oe <= strobe_oe_nxt;
      write_strobe_pu <= !ctrl_pullup_disable;
      data_oe <= data_oe_nxt;
    end
  end

  // ****************************************************************
  // Select pins, each shared with a port D line
  // ****************************************************************
  // Mode zero from reset gives the select function without setup
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sel
      emss_sel_pin u_pin (
        .clock(clock),
        .rst(rst),
        .emi_sel_n(emi_sel_n_nxt[gi]),
        .emi_oe(emi_oe_nxt[gi]),
        .gpio_mode(portd_gpio_mode[gi]),
        .gpio_dir(portd_gpio_dir[gi]),
        .gpio_out(portd_gpio_out[gi]),
        .pu_en(sel_pu_en[gi]),
        .pin_i(sel_i[gi]),
        .pin_o(sel_o[gi]),
        .pin_oe(sel_oe[gi]),
        .pin_pu(sel_pu[gi]),
        .gpio_in(portd_gpio_in[gi])
      );
    end
  endgenerate

endmodule : emss_top

// ### verification/emss_checker.sv
// Checker: write strobe, data and select pin timing of emss_top.
// Assumes it is bound to emss_top and sees only its ports.
`timescale 1ns/1ps
module emss_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_req,
  input wire logic wr_space,
  input wire logic wr_busy,
  input wire logic wr_done,
  input wire logic rd_active,
  input wire logic bus_idle_drive_bit,
  input wire logic ctrl_pullup_disable,
  input wire logic [15:0] portd_pullup_enable_reg,
  input wire logic [1:0] portd_gpio_mode,
  input wire logic [1:0] portd_gpio_dir,
  input wire logic [1:0] portd_gpio_out,
  input wire logic write_strobe_n_o,
  input wire logic write_strobe_oe,
  input wire logic write_strobe_pu,
  input wire logic [23:0] addr_o,
  input wire logic [15:0] data_o,
  input wire logic data_oe,
  input wire logic [1:0] sel_o,
  input wire logic [1:0] sel_oe,
  input wire logic [1:0] sel_pu
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ****
  // Write cycle steps
  // ****
  sequence s_take;
    wr_req && !wr_busy && !rd_active;
  endsequence
  sequence s_pulse;
    write_strobe_n_o ##1 !write_strobe_n_o [*3] ##1 write_strobe_n_o ##1 wr_done;
  endsequence
  a_strobe_seq: assert property (s_take |=> s_pulse)
    else $error("strobe pulse wrong");
  a_data_drive: assert property (!write_strobe_n_o |-> data_oe && write_strobe_oe)
    else $error("data not driven under strobe");
  a_data_hold: assert property ($rose(write_strobe_n_o) |-> data_oe && $stable(data_o))
    else $error("data lost at strobe rise");
  a_addr_stable: assert property (!write_strobe_n_o |-> $stable(addr_o) && !(&sel_o))
    else $error("address or select moved");
  a_strobe_float: assert property ($past(!bus_idle_drive_bit && !wr_busy && !wr_req &&
    !rd_active) |-> !write_strobe_oe) else $error("idle strobe driven");
  a_sel_float: assert property ($past(!bus_idle_drive_bit && !wr_busy && !wr_req &&
    !rd_active && !(|portd_gpio_mode)) |-> sel_oe == 2'h0) else $error("idle select driven");
  a_strobe_pu: assert property (!$past(rst) |-> write_strobe_pu != $past(ctrl_pullup_disable))
    else $error("strobe pull-up wrong");
  a_sel_pu: assert property (!$past(rst) |-> sel_pu == $past(portd_pullup_enable_reg[9:8]))
    else $error("select pull-up wrong");
  a_prog_sel: assert property (s_take and (!wr_space && !portd_gpio_mode[0]) |=>
    (!sel_o[0] && sel_oe[0]) [*5]) else $error("program select not low");
  a_data_sel: assert property (s_take and (wr_space && !portd_gpio_mode[1]) |=>
    (!sel_o[1] && sel_oe[1]) [*5]) else $error("data select not low");
  a_gpio_out: assert property ($past(!rst && portd_gpio_mode[0] && portd_gpio_dir[0]) |->
    sel_oe[0] && sel_o[0] == $past(portd_gpio_out[0])) else $error("port line wrong");
  a_reset_pins: assert property (disable iff (1'h0) rst && $past(rst) |->
    write_strobe_n_o && !write_strobe_oe && write_strobe_pu && sel_oe == 2'h0 && sel_pu == 2'h3)
    else $error("pins not at rest in reset");
endmodule : emss_checker

bind emss_top emss_checker u_chk (.*);

// ### verification/emss_sram_model.sv
// Behavioural external static RAM on the strobe, data and select pins.
// Assumes pins are sampled on the system clock.
`timescale 1ns/1ps
module emss_sram_model (
  input wire logic clock,
  input wire logic strobe_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] data,
  input wire logic data_oe,
  input wire logic [1:0] sel_n
);
  logic [15:0] mem [16];
  logic strobe_q;
  // ****
  // Capture on the strobe rise while a select is low
  // ****
  always @(posedge clock) begin
    strobe_q <= strobe_n;
    if (strobe_n && !strobe_q && !(&sel_n)) begin
      mem[{!sel_n[1], addr[2:0]}] <= data_oe ? data : 16'hxxxx;
    end
  end
endmodule : emss_sram_model

// ### verification/emss_top_tb.sv
// Testbench for emss_top: writes, idle drive, pull-ups and port mode.
// Assumes the bench drives every input on the falling clock edge.
`timescale 1ns/1ps
module emss_top_tb;
  logic clock = 1'h0, rst = 1'h1, wr_req = 1'h0, wr_space = 1'h0, rd_active = 1'h0;
  logic rd_space = 1'h0, drv = 1'h0, pud = 1'h0, wr_busy, wr_done;
  logic strobe_n, strobe_oe, strobe_pu, data_oe;
  logic [23:0] wr_addr = 24'h0, addr_o;
  logic [15:0] wr_data = 16'h0, pur = 16'hffff, data_o;
  logic [1:0] gmode = 2'h0, gdir = 2'h0, gout = 2'h0, ext_pad = 2'h3, gin, sel_o, sel_oe;
  logic [1:0] sel_pu, s;
  wire logic [1:0] sel_pad = (sel_oe & sel_o) | (~sel_oe & ext_pad);
  int error_cnt = 0, n_tests = 0;
  always #4 clock = ~clock;
  emss_top DUT (.clock(clock), .rst(rst), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_space(wr_space), .wr_busy(wr_busy), .wr_done(wr_done),
    .rd_active(rd_active), .rd_space(rd_space), .bus_idle_drive_bit(drv),
    .ctrl_pullup_disable(pud), .portd_pullup_enable_reg(pur), .portd_gpio_mode(gmode),
    .portd_gpio_dir(gdir), .portd_gpio_out(gout), .portd_gpio_in(gin),
    .write_strobe_n_o(strobe_n), .write_strobe_oe(strobe_oe), .write_strobe_pu(strobe_pu),
    .addr_o(addr_o), .data_o(data_o), .data_oe(data_oe), .sel_i(sel_pad), .sel_o(sel_o),
    .sel_oe(sel_oe), .sel_pu(sel_pu));
  emss_sram_model u_mem (.clock(clock), .strobe_n(strobe_n), .addr(addr_o), .data(data_o),
    .data_oe(data_oe), .sel_n(sel_o));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One write from idle; returns the select levels seen in the first bus cycle
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic sp,
                    output logic [1:0] sel);
    int n;
    wr_req = 1'h1;
    wr_addr = a;
    wr_data = d;
    wr_space = sp;
    @(negedge clock);
    wr_req = 1'h0;
    sel = sel_o;
    n = 0;
    while (wr_done !== 1'h1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk(n < 20, 1'h1);
  endtask : wr
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // ****
  // Tests
  // ****
  initial begin
    repeat (9) @(negedge clock);
    chk({strobe_n, strobe_oe, strobe_pu, sel_oe, sel_pu}, 7'h53);
    @(negedge clock);
    rst = 1'h0;
    $display("reset test done");
    wr(24'h000005, 16'ha5a5, 1'h0, s);
    chk(s, 2'h2);
    wr(24'h000006, 16'h5a5a, 1'h1, s);
    chk(s, 2'h1);
    chk(u_mem.mem[5], 16'ha5a5);
    chk(u_mem.mem[14], 16'h5a5a);
    @(negedge clock);
    chk({strobe_oe, sel_oe}, 3'h0);
    $display("write test done");
    rd_active = 1'h1;
    wr_req = 1'h1;
    repeat (2) @(negedge clock);
    chk({wr_busy, sel_o}, 3'h2);
    rd_space = 1'h1;
    wr_req = 1'h0;
    repeat (2) @(negedge clock);
    chk(sel_o, 2'h1);
    rd_active = 1'h0;
    drv = 1'h1;
    @(negedge clock);
    wr(24'hab0007, 16'h1234, 1'h1, s);
    @(negedge clock);
    chk({strobe_oe, sel_oe, strobe_n, sel_o}, 6'h3f);
    chk(u_mem.mem[15], 16'h1234);
    chk(addr_o, 24'hab0007);
    $display("drive test done");
    for (int i = 0; i < 2; i++) begin
      pud = i[0];
      pur = i[0] ? 16'h0100 : 16'h0200;
      repeat (2) @(negedge clock);
      chk({strobe_pu, sel_pu}, i[0] ? 3'h1 : 3'h6);
    end
    $display("pull-up test done");
    gmode = 2'h3;
    gdir = 2'h1;
    gout = 2'h1;
    ext_pad = 2'h0;
    repeat (5) @(negedge clock);
    chk({sel_oe, sel_o[0], gin}, 5'h0d);
    gout = 2'h0;
    ext_pad = 2'h2;
    repeat (5) @(negedge clock);
    chk({sel_oe, sel_o[0], gin}, 5'h0a);
    $display("port test done");
    wrap_up();
  end
  // Watchdog against a hung handshake
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule : emss_top_tb
